/* common/ulp_pkg.sv */
// Purpose: constants for the transceiver-side low pin interface logic
// Assumes: clk at 100 MHz, link clock sampled as a plain input
// Notes: register array holds transceiver configuration
// How it works
// - Strap pins are caught at power-up and at each reset release.
// - Strap code 00/01/10/11 selects 13, 19.2, 26, 24 MHz reference.
// - Eight-bit data bus plus three controls, single edge of link clock.
// - Dir high while device has data, low while watching for commands.
// - Dir stays high while the device cannot accept data, e.g. PLL start.
// - Each dir change gives one turnaround cycle; bus ignored then.
// - A bus value with bits 7:6 non-zero starts a transfer; other values mean idle.
// - Byte before the stop pulse is the last byte of the transfer.
// - Nxt marks the cycle a link byte is accepted, throttling transmit.
// - Low power mode stops clock out and shows line state on bits 1:0.
// - Low power mode raises interrupt on line, vbus or id change.
// - Stop input holds the device in PLL start and resumes it from low power.
// - One decoder steers link bytes to transmitter or register array.
// - Speed, termination, mode and pull-downs live in written registers.
// - Command bits 7:6: 01 transmit, 10 write, 11 read; 5:0 address.
package ulp_pkg;
	localparam int          DW          = 8;
	localparam int          FIFO_DEPTH  = 16;
	localparam int          AW          = 6;
	localparam int          NREG        = 64;
	localparam logic [1:0]  CMD_TX      = 2'h1;
	localparam logic [1:0]  CMD_WR      = 2'h2;
	localparam logic [1:0]  CMD_RD      = 2'h3;
	localparam logic [5:0]  A_FUNC      = 6'h04;
	localparam logic [5:0]  A_OTG       = 6'h0A;
	localparam logic [7:0]  FUNC_RST    = 8'h41;
	localparam logic [7:0]  OTG_RST     = 8'h06;
	localparam int          B_SUSPENDM  = 6;
	localparam int          B_TERM      = 2;
	localparam int          B_DPPD      = 1;
	localparam int          B_DMPD      = 2;
	localparam int          B_INT       = 3;
	localparam logic [1:0]  STRAP_WAIT  = 2'h2;
	localparam logic [1:0]  STRAP_DONE  = 2'h3;
	localparam logic [14:0] F_SEL0_KHZ  = 15'd13000;
	localparam logic [14:0] F_SEL1_KHZ  = 15'd19200;
	localparam logic [14:0] F_SEL2_KHZ  = 15'd26000;
	localparam logic [14:0] F_SEL3_KHZ  = 15'd24000;
	localparam int          RX_END_MAX  = 43;
	localparam int          NSYNC       = 17;
	typedef enum logic [3:0] {
		ST_PLL, ST_TA_IN, ST_IDLE, ST_TX, ST_WR_NXT, ST_WR_DAT, ST_WR_STP,
		ST_RD_NXT, ST_RD_TA, ST_RD_DAT, ST_TA_OUT, ST_SEND, ST_LPM
	} ulp_state_t;
endpackage

/* rtl/ulp_phy_top.sv */
// Purpose: device-side bus arbiter, decoder, register array and FIFO
// Assumes: link, strap and analog status pins come from outside clk domain and are synchronised
// Notes: link clock is sampled; its rising edges pace the bus
`timescale 1ns/1ps

module ulp_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// Drain side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int PW = $clog2(D);
	logic [W-1:0] mem_q [D];
	logic [PW:0]  wp_q, wp_d, rp_q, rp_d;
	logic         push, pop;

	assign in_ready  = (wp_q - rp_q) != (PW+1)'(D);
	assign out_valid = wp_q != rp_q;
	assign out_data  = mem_q[rp_q[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_q[wp_q[PW-1:0]] <= in_data;
	end
endmodule // ulp_fifo

module ulp_phy_top (
	input  wire logic                clk,
	input  wire logic                rstn,
	// Link pins
	input  wire logic                ulpi_clk_in,
	input  wire logic                stp,
	input  wire logic [ulp_pkg::DW-1:0] data_i,
	output logic [ulp_pkg::DW-1:0]   data_o,
	output logic                     data_oe,
	output logic                     dir,
	output logic                     nxt,
	output logic                     clkout,
	// Strap
	input  wire logic [1:0]          ref_clock_select_strap,
	output logic [1:0]               ref_sel,
	output logic [14:0]              ref_freq_khz,
	// Analog status
	input  wire logic                pll_locked,
	input  wire logic [1:0]          linestate,
	input  wire logic                vbus_valid,
	input  wire logic                id_dig,
	// Transmitter
	output logic [ulp_pkg::DW-1:0]   tx_data,
	output logic                     tx_valid,
	output logic                     tx_end,
	input  wire logic                tx_ready,
	// Receiver
	input  wire logic [ulp_pkg::DW-1:0] rx_data,
	input  wire logic                rx_valid,
	output logic                     rx_ready,
	// Configuration
	output logic [1:0]               xcvr_select,
	output logic                     term_select,
	output logic [1:0]               op_mode,
	output logic                     dp_pulldown,
	output logic                     dm_pulldown,
	output logic                     low_power
);
	import ulp_pkg::*;

	function automatic logic [14:0] freq_khz(input logic [1:0] s);
		case (s)
			2'h0:    freq_khz = F_SEL0_KHZ;
			2'h1:    freq_khz = F_SEL1_KHZ;
			2'h2:    freq_khz = F_SEL2_KHZ;
			default: freq_khz = F_SEL3_KHZ;
		endcase
	endfunction

	// Reset release and pin synchronisers
	logic [1:0]       rs_q;
	logic             rst_n;
	logic [NSYNC-1:0] s1_q, s2_q;
	logic             ck3_q, tick;
	logic             ck_s, stp_s, pll_s, vbus_s, id_s;
	logic [7:0]       bus_s;
	logic [1:0]       strap_s, ls_s;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rs_q <= '0;
		else
			rs_q <= {rs_q[0], 1'b1};
	end
	assign rst_n = rs_q[1];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			ck3_q <= 1'b0;
		end else begin
			s1_q  <= {ulpi_clk_in, stp, data_i, ref_clock_select_strap,
			          pll_locked, linestate, vbus_valid, id_dig};
			s2_q  <= s1_q;
			ck3_q <= s2_q[16];
		end
	end
	assign {ck_s, stp_s, bus_s, strap_s, pll_s, ls_s, vbus_s, id_s} = s2_q;
	assign tick = ck_s && !ck3_q;

	// Strap capture
	logic [1:0] cnt_q, cnt_d, sel_q, sel_d;
	always_comb begin
		cnt_d = cnt_q;
		sel_d = sel_q;
		if (cnt_q != STRAP_DONE)
			cnt_d = cnt_q + 2'h1;
		if (cnt_q == STRAP_WAIT)
			sel_d = strap_s;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			sel_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			sel_q <= sel_d;
		end
	end
	assign ref_sel      = sel_q;
	assign ref_freq_khz = freq_khz(sel_q);

	// Receive path buffer
	logic [7:0] fd;
	logic       fv, pop;
	ulp_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.in_data  (rx_data),
		.in_valid (rx_valid),
		.in_ready (rx_ready),
		.out_data (fd),
		.out_valid(fv),
		.out_ready(pop)
	);

	// Bus protocol
	ulp_state_t st_q, st_d;
	logic       dir_q, dir_d, pdir_q, pdir_d, nxt_q, nxt_d, int_q, int_d;
	logic       txv_d, txe_d, we, ck_q, ck_d;
	logic [7:0] do_q, do_d, txd_q, txd_d, wd_q, wd_d;
	logic [5:0] ad_q, ad_d;
	logic [3:0] mon_q;
	logic       txv_q, txe_q;
	logic [7:0] regs_q [NREG];

	always_comb begin
		st_d   = st_q;
		dir_d  = dir_q;
		nxt_d  = nxt_q;
		do_d   = do_q;
		ad_d   = ad_q;
		wd_d   = wd_q;
		txd_d  = txd_q;
		txv_d  = 1'b0;
		txe_d  = 1'b0;
		we     = 1'b0;
		pop    = 1'b0;
		pdir_d = tick ? dir_q : pdir_q;
		int_d  = int_q;
		ck_d   = ck_s && st_q != ST_LPM;
		if (st_q == ST_LPM) begin
			do_d = {4'h0, int_q, 1'b0, ls_s};
			if (mon_q != {ls_s, vbus_s, id_s})
				int_d = 1'b1;
			if (stp_s) begin
				st_d  = ST_TA_IN;
				dir_d = 1'b0;
				int_d = 1'b0;
			end
		end else if (tick) begin
			case (st_q)
				ST_PLL: begin
					dir_d = 1'b1;
					if (pll_s && !stp_s) begin
						dir_d = 1'b0;
						st_d  = ST_TA_IN;
					end
				end
				ST_TA_IN: st_d = ST_IDLE;
				ST_IDLE: begin
					if (!regs_q[A_FUNC][B_SUSPENDM]) begin
						st_d  = ST_LPM;
						dir_d = 1'b1;
					end else if (fv) begin
						dir_d = 1'b1;
						st_d  = ST_TA_OUT;
					end else if (bus_s != 8'h00) begin
						ad_d = bus_s[5:0];
						case (bus_s[7:6])
							CMD_TX: begin
								st_d  = ST_TX;
								nxt_d = tx_ready;
							end
							CMD_WR: begin
								st_d  = ST_WR_NXT;
								nxt_d = 1'b1;
							end
							CMD_RD: begin
								st_d  = ST_RD_NXT;
								nxt_d = 1'b1;
							end
							default: st_d = ST_IDLE;
						endcase
					end
				end
				ST_TX: begin
					if (stp_s) begin
						txe_d = 1'b1;
						nxt_d = 1'b0;
						st_d  = ST_IDLE;
					end else begin
						if (nxt_q) begin
							txd_d = bus_s;
							txv_d = 1'b1;
						end
						nxt_d = tx_ready;
					end
				end
				ST_WR_NXT: st_d = ST_WR_DAT;
				ST_WR_DAT: begin
					wd_d  = bus_s;
					nxt_d = 1'b0;
					st_d  = ST_WR_STP;
				end
				ST_WR_STP: begin
					if (stp_s) begin
						we   = 1'b1;
						st_d = ST_IDLE;
					end
				end
				ST_RD_NXT: begin
					nxt_d = 1'b0;
					dir_d = 1'b1;
					st_d  = ST_RD_TA;
				end
				ST_RD_TA: begin
					do_d = regs_q[ad_q];
					st_d = ST_RD_DAT;
				end
				ST_RD_DAT: begin
					dir_d = 1'b0;
					do_d  = 8'h00;
					st_d  = ST_TA_IN;
				end
				ST_TA_OUT: st_d = ST_SEND;
				ST_SEND: begin
					if (fv) begin
						do_d  = fd;
						pop   = 1'b1;
						nxt_d = 1'b1;
					end else begin
						do_d  = 8'h00;
						nxt_d = 1'b0;
						dir_d = 1'b0;
						st_d  = ST_TA_IN;
					end
				end
				default: st_d = ST_PLL;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= ST_PLL;
			dir_q  <= 1'b1;
			pdir_q <= 1'b1;
			nxt_q  <= 1'b0;
			do_q   <= '0;
			ad_q   <= '0;
			wd_q   <= '0;
			txd_q  <= '0;
			txv_q  <= 1'b0;
			txe_q  <= 1'b0;
			int_q  <= 1'b0;
			ck_q   <= 1'b0;
			mon_q  <= '0;
		end else begin
			st_q   <= st_d;
			dir_q  <= dir_d;
			pdir_q <= pdir_d;
			nxt_q  <= nxt_d;
			do_q   <= do_d;
			ad_q   <= ad_d;
			wd_q   <= wd_d;
			txd_q  <= txd_d;
			txv_q  <= txv_d;
			txe_q  <= txe_d;
			int_q  <= int_d;
			ck_q   <= ck_d;
			mon_q  <= {ls_s, vbus_s, id_s};
		end
	end

	// Register array; resume sets suspend bit back
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NREG; i++)
				regs_q[i] <= 8'h00;
			regs_q[A_FUNC] <= FUNC_RST;
			regs_q[A_OTG]  <= OTG_RST;
		end else if (we) begin
			regs_q[ad_q] <= wd_q;
		end else if (st_q == ST_LPM && stp_s) begin
			regs_q[A_FUNC][B_SUSPENDM] <= 1'b1;
		end
	end

	assign dir         = dir_q;
	assign nxt         = nxt_q;
	assign data_o      = do_q;
	assign data_oe     = dir_q && pdir_q;
	assign clkout      = ck_q;
	assign tx_data     = txd_q;
	assign tx_valid    = txv_q;
	assign tx_end      = txe_q;
	assign xcvr_select = regs_q[A_FUNC][1:0];
	assign term_select = regs_q[A_FUNC][B_TERM];
	assign op_mode     = regs_q[A_FUNC][4:3];
	assign dp_pulldown = regs_q[A_OTG][B_DPPD];
	assign dm_pulldown = regs_q[A_OTG][B_DMPD];
	assign low_power   = st_q == ST_LPM;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd_cmd;
		tick && st_q == ST_IDLE && regs_q[A_FUNC][B_SUSPENDM] && !fv
			&& bus_s[7:6] == CMD_RD;
	endsequence
	sequence s_rd_own;
		##[1:40] dir_q;
	endsequence

	a_pll_hold: assert property (st_q == ST_PLL |-> dir_q)
		else $error("dir low during PLL start");
	a_turn_quiet: assert property ($changed(dir_q) |-> !data_oe)
		else $error("bus driven in turnaround");
	a_tx_accept: assert property (tick && st_q == ST_TX && nxt_q && !stp_s
		|=> tx_valid && tx_data == $past(bus_s))
		else $error("accepted byte not forwarded");
	a_tx_last: assert property (tick && st_q == ST_TX && stp_s
		|=> tx_end && !nxt_q)
		else $error("stop did not end transfer");
	a_strap_hold: assert property (cnt_q == STRAP_DONE |=> $stable(sel_q))
		else $error("strap selection changed");
	a_freq_map: assert property (cnt_q == STRAP_DONE
		|-> ref_freq_khz == freq_khz(sel_q) && (sel_q != 2'h3 || ref_freq_khz == 15'd24000))
		else $error("wrong reference frequency");
	a_lpm_clock: assert property (st_q == ST_LPM && $past(st_q) == ST_LPM |-> !clkout)
		else $error("clock runs in low power");
	a_lpm_int: assert property (st_q == ST_LPM && !stp_s
		&& mon_q != {ls_s, vbus_s, id_s} |=> int_q)
		else $error("missed low power interrupt");
	a_idle_zero: assert property (tick && st_q == ST_IDLE && bus_s == 8'h00
		&& !fv && regs_q[A_FUNC][B_SUSPENDM] |=> st_q == ST_IDLE)
		else $error("idle bus started transfer");
	a_wr_commit: assert property (tick && st_q == ST_WR_STP && stp_s
		|=> regs_q[ad_q] == $past(wd_q))
		else $error("register write lost");
	a_rd_own: assert property (s_rd_cmd |-> s_rd_own)
		else $error("read did not take bus");
endmodule // ulp_phy_top

/* test/ulp_link_model.sv */
// Purpose: link-side partner that drives commands and data on the shared bus
// Assumes: lclk is the link clock; bus changes just after its falling edge
// Notes: a bus that nobody drives shows the inverse of its last value
`timescale 1ns/1ps

module ulp_link_model (
	// Clocks
	input  wire logic                   clk,
	input  wire logic                   lclk,
	// Device side of the bus
	input  wire logic                   dir,
	input  wire logic                   nxt,
	input  wire logic [ulp_pkg::DW-1:0] data_o,
	input  wire logic                   data_oe,
	// Link drive
	output logic                        stp,
	output logic [ulp_pkg::DW-1:0]      data_i
);
	import ulp_pkg::*;
	logic [7:0] drv_d;
	logic [7:0] last_q;
	logic       dir_f;
	int         hang;
	logic [7:0] rx_q [$];
	// Link drives only once dir has been seen low at a falling link clock edge
	assign data_i = data_oe ? data_o : (!dir && !dir_f ? drv_d : ~last_q);
	initial begin
		stp = 1'b0;
		drv_d = 8'h00;
		last_q = 8'h00;
		dir_f = 1'b1;
		hang = 0;
	end
	always @(posedge clk) last_q <= data_i;
	always @(negedge lclk) begin
		dir_f <= dir;
		if (dir && nxt && data_oe)
			rx_q.push_back(data_o);
	end
	task automatic step();
		@(negedge lclk);
		@(posedge clk);
	endtask
	task automatic idle_wait();
		int n;
		int z;
		z = 0;
		for (n = 0; n < 300 && z < 2; n++) begin
			step();
			z = (dir || dir_f) ? 0 : z + 1;
		end
		if (z < 2)
			hang++;
	endtask
	// Bytes go out one per accepted tick, then a one-tick stop
	task automatic send(input logic [7:0] b [$]);
		int n;
		logic p;
		idle_wait();
		drv_d <= b.pop_front();
		p = 1'b0;
		for (n = 0; n < 400; n++) begin
			step();
			if (p) begin
				if (b.size() == 0)
					break;
				drv_d <= b.pop_front();
			end
			p = nxt;
		end
		if (n == 400)
			hang++;
		stp <= 1'b1;
		drv_d <= 8'h00;
		step();
		stp <= 1'b0;
	endtask
	task automatic reg_read(input logic [5:0] a, output logic [7:0] d, output logic ta);
		int n;
		idle_wait();
		drv_d <= {CMD_RD, a};
		for (n = 0; n < 400 && !dir; n++)
			step();
		ta = ~data_oe;
		drv_d <= 8'h00;
		for (n = 0; n < 400 && !data_oe; n++)
			step();
		d = data_o;
		if (data_oe !== 1'b1)
			hang++;
	endtask
	task automatic wake();
		@(posedge clk);
		stp <= 1'b1;
		repeat (4) @(posedge clk);
		stp <= 1'b0;
	endtask
endmodule // ulp_link_model

/* test/tb.sv */
// Purpose: self-checking bench for the device-side bus logic
// Assumes: link clock of 160 ns, unrelated in phase to clk
// Notes: link clock is stopped to fill the receive buffer
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR %0t got %h exp %h", $time, a, b); end end
`define WAIT(c) begin for (w = 0; w < 3000 && !(c); w++) @(posedge clk); \
	if (!(c)) begin num_errors++; results(); end end

module tb;
	import ulp_pkg::*;
	logic clk, rstn, lclk, lclk_en, stp, data_oe, dir, nxt, clkout, pll_locked;
	logic vbus_valid, id_dig, tx_valid, tx_end, tx_ready, rx_valid, rx_ready;
	logic term_select, dp_pulldown, dm_pulldown, low_power;
	logic [7:0]  data_i, data_o, tx_data, rx_data;
	logic [1:0]  ref_clock_select_strap, ref_sel, linestate, xcvr_select, op_mode;
	logic [14:0] ref_freq_khz;
	logic [7:0]  txq [$];
	// 13000, 19200, 26000, 24000 kHz
	logic [14:0] fk [4] = '{15'h32C8, 15'h4B00, 15'h6590, 15'h5DC0};
	int w, num_errors, n_tests, n_end;

	ulp_phy_top uut (.clk, .rstn, .ulpi_clk_in(lclk), .stp, .data_i, .data_o, .data_oe,
		.dir, .nxt, .clkout, .ref_clock_select_strap, .ref_sel, .ref_freq_khz,
		.pll_locked, .linestate, .vbus_valid, .id_dig, .tx_data, .tx_valid, .tx_end,
		.tx_ready, .rx_data, .rx_valid, .rx_ready, .xcvr_select, .term_select,
		.op_mode, .dp_pulldown, .dm_pulldown, .low_power);
	ulp_link_model lnk (.clk, .lclk, .dir, .nxt, .data_o, .data_oe, .stp, .data_i);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#37;
		forever #80 lclk = lclk_en & ~lclk;
	end
	// Sampled mid-cycle so one-clock pulses are seen exactly once
	always @(negedge clk) begin
		if (tx_valid === 1'b1)
			txq.push_back(tx_data);
		if (tx_end === 1'b1)
			n_end++;
		if (lnk.hang != 0) begin
			num_errors++;
			results();
		end
	end

	task automatic results();
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic rst_dev(input logic [1:0] s);
		rstn <= 1'b0;
		pll_locked <= 1'b0;
		ref_clock_select_strap <= s;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (40) @(posedge clk);
		`CHK(dir, 1'b1)
		pll_locked <= 1'b1;
		`WAIT(dir === 1'b0)
		`CHK(ref_sel, s)
		`CHK(ref_freq_khz, fk[s])
	endtask
	task automatic t_strap();
		int i;
		for (i = 3; i >= 0; i--)
			rst_dev(2'(i));
		ref_clock_select_strap <= 2'h1;
		lnk.idle_wait();
		repeat (3) lnk.step();
		`CHK(ref_sel, 2'h0)
		`CHK(nxt, 1'b0)
	endtask
	task automatic t_cfg();
		logic [7:0] d;
		logic ta;
		`CHK({xcvr_select, term_select, op_mode, dp_pulldown, dm_pulldown}, 7'h23)
		lnk.reg_read(A_OTG, d, ta);
		`CHK(d, OTG_RST)
		`CHK(ta, 1'b1)
		lnk.send('{{CMD_WR, A_FUNC}, 8'h5A});
		lnk.send('{{CMD_WR, A_OTG}, 8'h00});
		`CHK({xcvr_select, term_select, op_mode, dp_pulldown, dm_pulldown}, 7'h4C)
		lnk.reg_read(A_FUNC, d, ta);
		`CHK(d, 8'h5A)
	endtask
	task automatic t_tx();
		int i;
		fork
			lnk.send('{{CMD_TX, 6'h05}, 8'hA0, 8'hA1, 8'hA2});
			repeat (6) begin
				repeat (24) @(posedge clk);
				tx_ready <= ~tx_ready;
			end
		join
		`CHK(txq.size(), 4)
		for (i = 0; i < 4; i++)
			`CHK(txq[i], i ? 8'(8'h9F + i) : {CMD_TX, 6'h05})
		`CHK(n_end, 1)
	endtask
	task automatic t_rx();
		int i;
		int k;
		logic p;
		lclk_en <= 1'b0;
		repeat (30) @(posedge clk);
		k = 0;
		rx_valid <= 1'b1;
		rx_data <= 8'h10;
		for (i = 0; i < 40; i++) begin
			// Ready as it stands before the pushing edge
			@(negedge clk);
			p = rx_ready;
			@(posedge clk);
			if (p === 1'b1) begin
				k++;
				rx_data <= 8'(8'h10 + k);
			end
		end
		rx_valid <= 1'b0;
		`CHK(k, FIFO_DEPTH)
		lclk_en <= 1'b1;
		`WAIT(lnk.rx_q.size() == 16)
		for (i = 0; i < 16; i++)
			`CHK(lnk.rx_q[i], 8'(8'h10 + i))
		`WAIT(dir === 1'b0)
	endtask
	task automatic t_lpm();
		logic [7:0] d;
		logic ta;
		int i;
		int h;
		linestate <= 2'h2;
		lnk.send('{{CMD_WR, A_FUNC}, 8'h01});
		`WAIT(low_power === 1'b1)
		repeat (8) @(posedge clk);
		`CHK({dir, data_o}, 9'h102)
		h = 0;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (clkout !== 1'b0)
				h++;
		end
		`CHK(h, 0)
		vbus_valid <= ~vbus_valid;
		repeat (8) @(posedge clk);
		`CHK(data_o[3], 1'b1)
		linestate <= 2'h1;
		repeat (8) @(posedge clk);
		`CHK(data_o[1:0], 2'h1)
		lnk.wake();
		`WAIT(low_power === 1'b0)
		h = 0;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (clkout === 1'b1)
				h++;
		end
		`CHK(h != 0, 1'b1)
		lnk.reg_read(A_FUNC, d, ta);
		`CHK(d, 8'h41)
	endtask

	initial begin
		rstn = 1'b0;
		lclk_en = 1'b1;
		pll_locked = 1'b0;
		ref_clock_select_strap = 2'h0;
		linestate = 2'h0;
		vbus_valid = 1'b0;
		id_dig = 1'b1;
		tx_ready = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
		num_errors = 0;
		n_tests = 0;
		n_end = 0;
		t_strap();
		t_cfg();
		t_tx();
		t_rx();
		t_lpm();
		results();
	end
endmodule // tb
